/* File: watchdog_timer_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end

module watchdog_timer_unit_bench
    import wdt_pkg::*;
;
    // Small dividers keep every interval short
    localparam int unsigned T_SLOW = 32;
    localparam int unsigned T_FAST = 4;
    logic clock;
    logic resetn;
    wdt_apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wdt_reset_req;
    logic [31:0] rd;
    logic [31:0] c0;
    logic err;
    int n_fail;
    int total_checks;

    wdt_top #(.SLOW_DIV(T_SLOW), .FAST_DIV(T_FAST)) dut (
        .clock(clock),
        .resetn(resetn),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .wdt_reset_req(wdt_reset_req)
    );

    always #20 clock = ~clock;

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1, "no pready")
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
            input string m);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e, m)
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #800000;
        n_fail++;
        close_out();
    end

    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        req = '0;
        n_fail = 0;
        total_checks = 0;
        idle(8);
        resetn <= 1'b1;
        // Armed and counting with no set-up
        rdchk(OFS_CTRL, 32'h7, "ctrl after reset");
        rdchk(OFS_RELOAD, 32'hff00, "reload after reset");
        rdchk(OFS_MASK, 32'h1, "mask after reset");
        rdchk(OFS_STATUS, 32'h0, "status after reset");
        apb(1'b0, OFS_COUNT, 32'h0);
        c0 = rd;
        idle(20);
        apb(1'b0, OFS_COUNT, 32'h0);
        `CHK(rd !== c0, 1'b1, "count frozen after reset")
        $display("test reset values done");
        // Unmapped place is refused
        wr(8'h40, 32'hffff_ffff);
        `CHK(err, 1'b1, "no error on unmapped write")
        rdchk(8'h40, 32'h0, "unmapped read data");
        `CHK(err, 1'b1, "no error on unmapped read")
        $display("test unmapped done");
        // Service and disable in one write: load, then hold
        wr(OFS_RELOAD, 32'h1234);
        wr(OFS_CMD, 32'h3);
        rdchk(OFS_COUNT, 32'h1234, "service load");
        rdchk(OFS_CTRL, 32'h5, "ctrl disabled");
        idle(40);
        rdchk(OFS_COUNT, 32'h1234, "count moved while off");
        wr(OFS_CMD, 32'h4);
        idle(40);
        rdchk(OFS_CTRL, 32'h7, "ctrl enabled");
        apb(1'b0, OFS_COUNT, 32'h0);
        `CHK(rd > 32'h1234, 1'b1, "no counting after enable")
        $display("test disable enable done");
        // 256 fast ticks per interval: prewarn, then reset request
        wr(OFS_RELOAD, 32'hff00);
        wr(OFS_CMD, 32'h1);
        wr(OFS_STATUS, 32'h3);
        idle(1100);
        `CHK(irq, 1'b1, "no prewarn irq")
        `CHK(wdt_reset_req, 1'b0, "early reset request")
        rdchk(OFS_STATUS, 32'h1, "status after prewarn");
        rdchk(OFS_CTRL, 32'hf, "ctrl prewarn phase");
        wr(OFS_CMD, 32'h1);
        rdchk(OFS_CTRL, 32'h7, "service left prewarn");
        wr(OFS_STATUS, 32'h1);
        idle(2);
        `CHK(irq, 1'b0, "irq not cleared")
        idle(1100);
        `CHK(wdt_reset_req, 1'b0, "service did not restart")
        rdchk(OFS_STATUS, 32'h1, "second prewarn");
        idle(1000);
        `CHK(wdt_reset_req, 1'b1, "no reset request")
        rdchk(OFS_STATUS, 32'h3, "status after reset request");
        wr(OFS_MASK, 32'h0);
        idle(2);
        `CHK(irq, 1'b0, "irq not masked")
        wr(OFS_MASK, 32'h2);
        idle(2);
        `CHK(irq, 1'b1, "reset event irq")
        wr(OFS_STATUS, 32'h3);
        idle(2);
        `CHK(irq, 1'b0, "irq after clear")
        wr(OFS_MASK, 32'h1);
        $display("test escalation done");
        // Slow divider is taken at the service, not at the CTRL write
        wr(OFS_CMD, 32'h2);
        wr(OFS_RELOAD, 32'hffff);
        wr(OFS_CTRL, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd[2:0], 3'b100, "divider changed early")
        wr(OFS_CMD, 32'h3);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd[3:0], 4'b0000, "divider not taken")
        wr(OFS_STATUS, 32'h3);
        wr(OFS_CMD, 32'h4);
        idle(20);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[0], 1'b0, "slow tick too fast")
        idle(20);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[0], 1'b1, "slow overflow missing")
        wr(OFS_CMD, 32'h2);
        $display("test slow divider done");
        // Second reset in mid-run re-arms the watchdog
        resetn <= 1'b0;
        idle(3);
        `CHK(wdt_reset_req, 1'b0, "reset request kept")
        `CHK(irq, 1'b0, "irq kept in reset")
        resetn <= 1'b1;
        rdchk(OFS_CTRL, 32'h7, "ctrl after second reset");
        rdchk(OFS_RELOAD, 32'hff00, "reload after second reset");
        $display("test second reset done");
        close_out();
    end
endmodule

`default_nettype wire

/* File: wdt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

package wdt_pkg;
    // System clock and the divider ratios of the tick prescaler
    localparam int unsigned SYS_CLK_HZ = 25_000_000;
    localparam int unsigned DIV_SLOW = 16384;
    localparam int unsigned DIV_FAST = 256;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;

    // Default interval: 256 fast ticks, 6.5 ms at a 10 MHz clock
    localparam int unsigned REF_CLK_HZ = 10_000_000;
    localparam int unsigned DEFAULT_TICKS = 256;
    localparam int unsigned DEFAULT_CYCLES = DEFAULT_TICKS * DIV_FAST;
    localparam int unsigned DEFAULT_INTERVAL_US =
        DEFAULT_CYCLES / (REF_CLK_HZ / 1_000_000);

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;

    // Field positions
    localparam int unsigned CTRL_DIV_SEL = 0;
    localparam int unsigned CTRL_ENABLED = 1;
    localparam int unsigned CTRL_DIV_ACT = 2;
    localparam int unsigned CTRL_PREWARN = 3;
    localparam int unsigned CTRL_RST_REQ = 4;
    localparam int unsigned CMD_SERVICE = 0;
    localparam int unsigned CMD_DISABLE = 1;
    localparam int unsigned CMD_ENABLE = 2;
    localparam int unsigned EV_PREWARN = 0;
    localparam int unsigned EV_RST_REQ = 1;
    localparam int unsigned EV_W = 2;

    // Reset values
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'hff00;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'hff00;
    localparam logic DIV_SEL_RST = 1'h1;
    localparam logic ENABLED_RST = 1'h1;
    localparam logic [EV_W-1:0] MASK_RST = 2'h1;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

    typedef enum logic [0:0] {
        WDT_PH_NORMAL = 1'b0,
        WDT_PH_PREWARN = 1'b1
    } wdt_phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } wdt_apb_req_t;
endpackage

module wdt_prescaler
    import wdt_pkg::*;
#(
    parameter int unsigned SLOW_DIV = DIV_SLOW,
    parameter int unsigned FAST_DIV = DIV_FAST
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic clear,
    input wire logic fast_sel,
    // Tick out
    output logic tick
);
    localparam int unsigned PW = $clog2(SLOW_DIV);

    typedef struct packed {
        logic [PW-1:0] cnt;
    } wdt_psc_state_t;

    wdt_psc_state_t s_r;
    wdt_psc_state_t s_nxt;
    logic [PW-1:0] last;

    assign last = fast_sel ? PW'(FAST_DIV - 1) : PW'(SLOW_DIV - 1);
    assign tick = run && !clear && (s_r.cnt == last); // see R5

    always_comb
    begin
        s_nxt = s_r;
        if (clear)
        begin
            s_nxt.cnt = '0; // see R7
        end
        else if (run)
        begin
            s_nxt.cnt = tick ? '0 : s_r.cnt + PW'(1); // see R5
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_tick_spacing;
        tick |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // see R5
        else $error("prescaler ticked twice in a row");

    property p_tick_limit;
        tick |-> s_r.cnt == (fast_sel ? PW'(FAST_DIV - 1) : PW'(SLOW_DIV - 1))
            ##1 s_r.cnt == '0;
    endproperty
    a_tick_limit: assert property (p_tick_limit) // see R5
        else $error("prescaler tick at wrong count");

    property p_hold_stopped;
        !run && !clear |=> $stable(s_r.cnt);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) // see R10
        else $error("prescaler moved while stopped");
endmodule

`default_nettype wire

/* File: wdt_top.sv */
// Summary of operation
// R1 - Watchdog comes out of every reset already counting.
// R2 - Disable and enable commands stop and restart it at any time.
// R3 - Software must service before the counter overflows.
// R4 - Overflow raises the prewarning first, a reset request afterwards.
// R5 - Sixteen-bit counter stepped by a prescaler dividing by 16384 or 256.
// R6 - Counter loads its start value from the reload register.
// R7 - A service loads the reload value and clears the prescaler together.
// R8 - Reset defaults give 6.5 ms at a 10 MHz clock.
// R9 - At 80 MHz intervals span 3.2 us to 13.4 s.
// R10 - Counts up from reload, overflows past all-ones, holds when disabled.
// R11 - Divider selection is taken over at the next service or reload.
`timescale 1ns/1ps
`default_nettype none

module wdt_top
    import wdt_pkg::*;
#(
    parameter int unsigned SLOW_DIV = DIV_SLOW,
    parameter int unsigned FAST_DIV = DIV_FAST
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire wdt_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System side
    output logic irq,
    output logic wdt_reset_req
);
    typedef struct packed {
        logic enabled;
        logic div_sel_cfg;
        logic div_sel_act;
        wdt_phase_t phase;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] count;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic rst_req;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wdt_state_t;

    wdt_state_t s_r;
    wdt_state_t s_nxt;
    logic tick;
    logic wr_fire;
    logic rd_fire;
    logic svc;
    logic dis_cmd;
    logic en_cmd;
    logic overflow;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_RELOAD) ||
            (a == OFS_COUNT) || (a == OFS_STATUS) || (a == OFS_MASK);
    endfunction

    function automatic logic hit_wr(input wdt_apb_req_t r,
        input logic [ADDR_W-1:0] a, input logic fire);
        hit_wr = fire && r.pwrite && (r.paddr == a);
    endfunction

    // One wait state: the access cycle reads state, the next edge answers
    assign rd_fire = apb_req.psel && apb_req.penable && !s_r.pready;
    assign wr_fire = apb_req.psel && apb_req.penable && s_r.pready;

    // Instructions arrive as command register writes
    assign svc = hit_wr(apb_req, OFS_CMD, wr_fire) &&
        apb_req.pwdata[CMD_SERVICE];
    assign dis_cmd = hit_wr(apb_req, OFS_CMD, wr_fire) &&
        apb_req.pwdata[CMD_DISABLE];
    assign en_cmd = hit_wr(apb_req, OFS_CMD, wr_fire) &&
        apb_req.pwdata[CMD_ENABLE];

    assign overflow = tick && !svc && (s_r.count == CNT_MAX); // see R10

    wdt_prescaler #(
        .SLOW_DIV(SLOW_DIV),
        .FAST_DIV(FAST_DIV)
    ) u_psc (
        .clock(clock),
        .resetn(resetn),
        .run(s_r.enabled), // see R10
        .clear(svc), // see R7
        .fast_sel(s_r.div_sel_act),
        .tick(tick)
    );

    always_comb
    begin
        s_nxt = s_r;
        ev_set = '0;
        ev_clr = '0;

        // Counter and escalation
        if (svc)
        begin
            s_nxt.count = s_r.reload; // see R6
            s_nxt.div_sel_act = s_r.div_sel_cfg; // see R11
            s_nxt.phase = WDT_PH_NORMAL;
        end
        else if (overflow)
        begin
            s_nxt.count = s_r.reload; // see R6
            s_nxt.div_sel_act = s_r.div_sel_cfg; // see R11
            case (s_r.phase)
                WDT_PH_NORMAL:
                begin
                    s_nxt.phase = WDT_PH_PREWARN; // see R4
                    ev_set[EV_PREWARN] = 1'b1;
                end
                WDT_PH_PREWARN:
                begin
                    s_nxt.rst_req = 1'b1; // see R4
                    ev_set[EV_RST_REQ] = 1'b1;
                end
                default:
                begin
                    s_nxt.phase = WDT_PH_NORMAL;
                end
            endcase
        end
        else if (tick)
        begin
            s_nxt.count = s_r.count + CNT_W'(1); // see R10
        end

        // Disable wins if both command bits are written together
        if (dis_cmd)
        begin
            s_nxt.enabled = 1'b0; // see R2
        end
        else if (en_cmd)
        begin
            s_nxt.enabled = 1'b1; // see R2
        end

        // Register writes
        if (hit_wr(apb_req, OFS_CTRL, wr_fire))
        begin
            s_nxt.div_sel_cfg = apb_req.pwdata[CTRL_DIV_SEL]; // see R11
        end
        else if (hit_wr(apb_req, OFS_RELOAD, wr_fire))
        begin
            s_nxt.reload = apb_req.pwdata[CNT_W-1:0]; // see R6, R9
        end
        else if (hit_wr(apb_req, OFS_STATUS, wr_fire))
        begin
            ev_clr = apb_req.pwdata[EV_W-1:0];
        end
        else if (hit_wr(apb_req, OFS_MASK, wr_fire))
        begin
            s_nxt.mask = apb_req.pwdata[EV_W-1:0];
        end

        // Sticky events: a set in the clearing cycle survives
        s_nxt.status = (s_r.status & ~ev_clr) | ev_set;
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);

        // Bus answer
        s_nxt.pready = rd_fire;
        s_nxt.pslverr = rd_fire && !mapped(apb_req.paddr);
        s_nxt.prdata = '0;
        if (rd_fire && !apb_req.pwrite)
        begin
            if (apb_req.paddr == OFS_CTRL)
            begin
                s_nxt.prdata[CTRL_DIV_SEL] = s_r.div_sel_cfg;
                s_nxt.prdata[CTRL_ENABLED] = s_r.enabled;
                s_nxt.prdata[CTRL_DIV_ACT] = s_r.div_sel_act;
                s_nxt.prdata[CTRL_PREWARN] = s_r.phase == WDT_PH_PREWARN;
                s_nxt.prdata[CTRL_RST_REQ] = s_r.rst_req;
            end
            else if (apb_req.paddr == OFS_RELOAD)
            begin
                s_nxt.prdata[CNT_W-1:0] = s_r.reload;
            end
            else if (apb_req.paddr == OFS_COUNT)
            begin
                s_nxt.prdata[CNT_W-1:0] = s_r.count;
            end
            else if (apb_req.paddr == OFS_STATUS)
            begin
                s_nxt.prdata[EV_W-1:0] = s_r.status;
            end
            else if (apb_req.paddr == OFS_MASK)
            begin
                s_nxt.prdata[EV_W-1:0] = s_r.mask;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r.enabled <= ENABLED_RST; // see R1
            s_r.div_sel_cfg <= DIV_SEL_RST; // see R8
            s_r.div_sel_act <= DIV_SEL_RST; // see R8
            s_r.phase <= WDT_PH_NORMAL;
            s_r.reload <= RELOAD_RST; // see R8
            s_r.count <= COUNT_RST;
            s_r.status <= '0;
            s_r.mask <= MASK_RST;
            s_r.rst_req <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.prdata <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Every output is a flip-flop of the state record
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;
    assign wdt_reset_req = s_r.rst_req;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_first_overflow;
        overflow && s_r.phase == WDT_PH_NORMAL;
    endsequence

    // A request held over from an earlier escalation survives a service
    sequence s_prewarn_raised;
        s_r.status[EV_PREWARN] && s_r.phase == WDT_PH_PREWARN &&
            $stable(s_r.rst_req) && (s_r.irq || !s_r.mask[EV_PREWARN]);
    endsequence

    property p_armed_after_reset;
        !$past(resetn) |-> s_r.enabled && s_r.reload == RELOAD_RST;
    endproperty
    a_armed_after_reset: assert property (p_armed_after_reset) // see R1
        else $error("watchdog not armed after reset");

    property p_disable;
        dis_cmd |=> !s_r.enabled ##1 !tick;
    endproperty
    a_disable: assert property (p_disable) // see R2
        else $error("disable command did not stop the watchdog");

    property p_enable;
        en_cmd && !dis_cmd |=> s_r.enabled;
    endproperty
    a_enable: assert property (p_enable) // see R2
        else $error("enable command did not restart the watchdog");

    property p_prewarn_first;
        s_first_overflow |=> s_prewarn_raised;
    endproperty
    a_prewarn_first: assert property (p_prewarn_first) // see R4
        else $error("first overflow did not raise the prewarning");

    property p_rst_after_prewarn;
        $rose(s_r.rst_req) |-> $past(s_r.phase) == WDT_PH_PREWARN;
    endproperty
    a_rst_after_prewarn: assert property (p_rst_after_prewarn) // see R4
        else $error("reset request without prior prewarning");

    property p_service_load;
        svc |=> s_r.count == $past(s_r.reload) && u_psc.s_r.cnt == '0;
    endproperty
    a_service_load: assert property (p_service_load) // see R7
        else $error("service did not reload counter and clear prescaler");

    property p_count_step;
        tick && !svc && s_r.count != CNT_MAX
            |=> s_r.count == $past(s_r.count) + CNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) // see R10
        else $error("counter did not step up on tick");

    property p_hold_disabled;
        !s_r.enabled && !svc |=> $stable(s_r.count);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) // see R10
        else $error("counter moved while disabled");

    property p_overflow_reload;
        overflow |=> s_r.count == $past(s_r.reload);
    endproperty
    a_overflow_reload: assert property (p_overflow_reload) // see R6
        else $error("overflow did not reload the counter");

    property p_div_taken_late;
        $changed(s_r.div_sel_act) |-> $past(svc || overflow);
    endproperty
    a_div_taken_late: assert property (p_div_taken_late) // see R11
        else $error("divider changed outside service or reload");

    property p_answer_one_wait;
        apb_req.psel && apb_req.penable && !s_r.pready |=> s_r.pready;
    endproperty
    a_answer_one_wait: assert property (p_answer_one_wait)
        else $error("bus answer not given after one wait state");
endmodule

`default_nettype wire
